/* File: core/amp_reg_map.sv */
`timescale 1ns/100ps
`include "amp_regs_params.svh"
module amp_reg_map
   import amp_regs_pkg::*;
#(
   parameter int TRIM_CYCLES = `TRIM_WAIT_MS * `CLK_FREQ_KHZ
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   input  wire logic       addrSel,
   input  wire logic [7:0] faultEvent,
   output logic            sdaOut,
   output logic            sdaOe,
   output logic            shutdownActive,
   output logic            trimBusy
);

   amp_state_t state_reg;
   amp_state_t state_next;

   // Register length by subaddress; zero marks reserved space
   function automatic logic [4:0] regLen(input logic [7:0] sa);
      logic [4:0] len;
      len = 5'h00;
      if (sa <= `SA_CH3_GAIN || sa == `SA_GAIN_SETUP
          || (sa >= `SA_MOD_CEILING && sa <= `SA_DELAY_FOURTH)
          || (sa >= `SA_SHUTDOWN_GROUP && sa <= `SA_BACKEND_FAULT)) begin
         len = `LEN_SHORT;
      end else if (sa == `SA_INPUT_ROUTING || sa == `SA_CH4_SOURCE
                   || sa == `SA_OUTPUT_ROUTING) begin
         len = `LEN_WORD;
      end else if (sa == `SA_LEFT_FILTER0 || sa == `SA_LEFT_FILTER1) begin
         len = `LEN_FILTER;
      end
      return len;
   endfunction

   // Byte position in the image
   function automatic logic [6:0] regIdx(input logic [7:0] sa, input logic [4:0] bc);
      logic [6:0] idx;
      idx = 7'h00;
      case (sa)
         `SA_INPUT_ROUTING:  idx = `IMG_INPUT_ROUTE + {2'b00, bc};
         `SA_CH4_SOURCE:     idx = `IMG_CH4_SOURCE + {2'b00, bc};
         `SA_OUTPUT_ROUTING: idx = `IMG_OUTPUT_ROUTE + {2'b00, bc};
         `SA_LEFT_FILTER0:   idx = `IMG_FILTER0 + {2'b00, bc};
         `SA_LEFT_FILTER1:   idx = `IMG_FILTER1 + {2'b00, bc};
         default:            idx = sa[6:0];
      endcase
      return idx;
   endfunction

   function automatic reg_image_t resetImage();
      reg_image_t im;
      im = '0;
      im[`SA_CLOCK_RATE]      = `RST_CLOCK_RATE;
      im[`SA_FAULT_STATUS]    = `RST_FAULT_STATUS;
      im[`SA_SYS_CTRL_FIRST]  = `RST_SYS_CTRL_FIRST;
      im[`SA_AUDIO_FORMAT]    = `RST_AUDIO_FORMAT;
      im[`SA_SYS_CTRL_SECOND] = `RST_SYS_CTRL_SECOND;
      im[`SA_GENTLE_SILENCE]  = `RST_GENTLE_SILENCE;
      im[`SA_GLOBAL_GAIN]     = `RST_GLOBAL_GAIN;
      im[`SA_CH1_GAIN]        = `RST_CH_GAIN;
      im[`SA_CH2_GAIN]        = `RST_CH_GAIN;
      im[`SA_CH3_GAIN]        = `RST_CH_GAIN;
      im[`SA_GAIN_SETUP]      = `RST_GAIN_SETUP;
      im[`SA_MOD_CEILING]     = `RST_MOD_CEILING;
      im[`SA_DELAY_FIRST]     = `RST_DELAY_A;
      im[`SA_DELAY_SECOND]    = `RST_DELAY_B;
      im[`SA_DELAY_THIRD]     = `RST_DELAY_A;
      im[`SA_DELAY_FOURTH]    = `RST_DELAY_B;
      im[`SA_SHUTDOWN_GROUP]  = `RST_SHUTDOWN_GROUP;
      im[`SA_RAMP_PERIOD]     = `RST_RAMP_PERIOD;
      im[`SA_OSC_CAL]         = `RST_OSC_CAL;
      im[`SA_BACKEND_FAULT]   = `RST_BACKEND_FAULT;
      // Shift and cut, since a literal takes no part-select
      for (int b = 0; b < 4; b++) begin
         im[`IMG_INPUT_ROUTE + b]  = 8'(`RST_INPUT_ROUTING >> (24 - 8 * b));
         im[`IMG_CH4_SOURCE + b]   = 8'(`RST_CH4_SOURCE >> (24 - 8 * b));
         im[`IMG_OUTPUT_ROUTE + b] = 8'(`RST_OUTPUT_ROUTING >> (24 - 8 * b));
         im[`IMG_FILTER0 + b]      = 8'(`RST_COEF_B0 >> (24 - 8 * b));
         im[`IMG_FILTER1 + b]      = 8'(`RST_COEF_B0 >> (24 - 8 * b));
      end
      return im;
   endfunction

   // Read view; the fixed identity and reserved space are not in the image
   function automatic logic [7:0] readByte(input reg_image_t im, input logic [7:0] sa,
                                           input logic [4:0] bc);
      logic [7:0] d;
      d = 8'h00;
      if (sa == `SA_PART_ID) begin
         d = `PART_ID_VALUE; // Arbitrary identity value
      end else if (regLen(sa) != 5'h00) begin
         d = im[regIdx(sa, bc)];
      end
      return d;
   endfunction

   always_comb begin
      logic       rise;
      logic       fall;
      logic       startCond;
      logic       stopCond;
      logic [4:0] len;
      logic [7:0] wbyte;
      logic [7:0] rbyte;
      logic       advance;
      rise      = 1'b0;
      fall      = 1'b0;
      startCond = 1'b0;
      stopCond  = 1'b0;
      len       = 5'h00;
      wbyte     = 8'h00;
      rbyte     = 8'h00;
      advance   = 1'b0;
      state_next = state_reg;
      state_next.sclPrev = sclIn;
      state_next.sdaPrev = sdaIn;
      rise      = sclIn & ~state_reg.sclPrev;
      fall      = ~sclIn & state_reg.sclPrev;
      startCond = sclIn & state_reg.sclPrev & state_reg.sdaPrev & ~sdaIn;
      stopCond  = sclIn & state_reg.sclPrev & ~state_reg.sdaPrev & sdaIn;
      len       = regLen(state_reg.sub);

      // Hardware faults stay sticky; a clear in the same cycle loses
      state_next.img[`SA_FAULT_STATUS] = state_reg.img[`SA_FAULT_STATUS] | faultEvent;

      if (state_reg.trimBusy) begin
         if (state_reg.trimCnt == '0) begin
            state_next.trimBusy = 1'b0;
         end else begin
            state_next.trimCnt = state_reg.trimCnt - 1'b1;
         end
      end

      if (startCond) begin
         state_next.phase   = PH_RECV;
         state_next.bitCnt  = 4'h0;
         state_next.gotAddr = 1'b0;
         state_next.sdaOe   = 1'b0;
      end else if (stopCond) begin
         state_next.phase = PH_IDLE;
         state_next.sdaOe = 1'b0;
      end else begin
         case (state_reg.phase)
            PH_IDLE: begin
               state_next.sdaOe = 1'b0;
            end
            PH_RECV: begin
               if (rise) begin
                  state_next.shift  = {state_reg.shift[6:0], sdaIn};
                  state_next.bitCnt = state_reg.bitCnt + 4'h1;
               end else if (fall && state_reg.bitCnt == 4'h8) begin
                  state_next.sdaOe = 1'b1;
                  state_next.phase = PH_ACKOUT;
                  if (!state_reg.gotAddr) begin
                     if (state_reg.shift[7:1] == {`BUS_ADDR_BASE, addrSel}) begin
                        state_next.gotAddr  = 1'b1;
                        state_next.readMode = state_reg.shift[0];
                     end else begin
                        state_next.sdaOe = 1'b0;
                        state_next.phase = PH_IDLE;
                     end
                  end else if (!state_reg.gotSub) begin
                     state_next.sub     = state_reg.shift;
                     state_next.byteCnt = 5'h00;
                     state_next.gotSub  = 1'b1;
                  end else begin
                     wbyte = state_reg.shift;
                     // Top six coefficient bits are never stored
                     if (len == `LEN_FILTER && state_reg.byteCnt[1:0] == 2'b00) begin
                        wbyte = wbyte & `COEF_TOP_MASK;
                     end
                     // Reserved space and the identity ignore writes
                     if (len != 5'h00 && state_reg.sub != `SA_PART_ID) begin
                        state_next.img[regIdx(state_reg.sub, state_reg.byteCnt)] = wbyte;
                        if (state_reg.sub == `SA_FAULT_STATUS) begin
                           state_next.img[`SA_FAULT_STATUS] = wbyte | faultEvent;
                        end
                     end
                     if (state_reg.sub == `SA_SYS_CTRL_SECOND) begin
                        state_next.shutdown = wbyte[`SHUTDOWN_BIT];
                     end
                     if (state_reg.sub == `SA_OSC_CAL && wbyte == `TRIM_START_VALUE) begin
                        state_next.trimBusy = 1'b1;
                        state_next.trimCnt  = `TRIM_CNT_BITS'(TRIM_CYCLES - 1);
                     end
                     advance = 1'b1;
                  end
               end
            end
            PH_ACKOUT: begin
               if (fall) begin
                  state_next.bitCnt = 4'h0;
                  if (state_reg.readMode) begin
                     rbyte = readByte(state_reg.img, state_reg.sub, state_reg.byteCnt);
                     state_next.sdaOe = ~rbyte[7];
                     state_next.shift = {rbyte[6:0], 1'b0};
                     state_next.phase = PH_SEND;
                     advance = 1'b1;
                  end else begin
                     state_next.sdaOe = 1'b0;
                     state_next.phase = PH_RECV;
                  end
               end
            end
            PH_SEND: begin
               if (rise) begin
                  state_next.bitCnt = state_reg.bitCnt + 4'h1;
               end else if (fall) begin
                  if (state_reg.bitCnt == 4'h8) begin
                     state_next.sdaOe = 1'b0;
                     state_next.phase = PH_ACKIN;
                  end else begin
                     state_next.sdaOe = ~state_reg.shift[7];
                     state_next.shift = {state_reg.shift[6:0], 1'b0};
                  end
               end
            end
            PH_ACKIN: begin
               if (rise) begin
                  state_next.acked = ~sdaIn;
               end else if (fall) begin
                  state_next.bitCnt = 4'h0;
                  if (state_reg.acked) begin
                     rbyte = readByte(state_reg.img, state_reg.sub, state_reg.byteCnt);
                     state_next.sdaOe = ~rbyte[7];
                     state_next.shift = {rbyte[6:0], 1'b0};
                     state_next.phase = PH_SEND;
                     advance = 1'b1;
                  end else begin
                     state_next.phase = PH_IDLE;
                  end
               end
            end
            default: begin
               state_next.phase = PH_IDLE;
            end
         endcase
      end

      // Walk through the bytes of a register, then on to the next subaddress
      if (advance) begin
         if (len == 5'h00 || state_reg.byteCnt + 5'h01 == len) begin
            state_next.sub     = state_reg.sub + 8'h01;
            state_next.byteCnt = 5'h00;
         end else begin
            state_next.byteCnt = state_reg.byteCnt + 5'h01;
         end
      end
      if (stopCond) begin
         state_next.gotSub = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg          <= '0;
         state_reg.phase    <= PH_IDLE;
         state_reg.sclPrev  <= 1'b1;
         state_reg.sdaPrev  <= 1'b1;
         state_reg.shutdown <= 1'b1;
         state_reg.img      <= resetImage();
      end else begin
         state_reg <= state_next;
      end
   end

   assign sdaOut         = state_reg.sdaOut;
   assign sdaOe          = state_reg.sdaOe;
   assign shutdownActive = state_reg.shutdown;
   assign trimBusy       = state_reg.trimBusy;

endmodule

/* File: core/amp_regs_params.svh */
`ifndef AMP_REGS_PARAMS_SVH
`define AMP_REGS_PARAMS_SVH

// Subaddresses
`define SA_CLOCK_RATE      8'h00
`define SA_PART_ID         8'h01
`define SA_FAULT_STATUS    8'h02
`define SA_SYS_CTRL_FIRST  8'h03
`define SA_AUDIO_FORMAT    8'h04
`define SA_SYS_CTRL_SECOND 8'h05
`define SA_GENTLE_SILENCE  8'h06
`define SA_GLOBAL_GAIN     8'h07
`define SA_CH1_GAIN        8'h08
`define SA_CH2_GAIN        8'h09
`define SA_CH3_GAIN        8'h0A
`define SA_GAIN_SETUP      8'h0E
`define SA_MOD_CEILING     8'h10
`define SA_DELAY_FIRST     8'h11
`define SA_DELAY_SECOND    8'h12
`define SA_DELAY_THIRD     8'h13
`define SA_DELAY_FOURTH    8'h14
`define SA_SHUTDOWN_GROUP  8'h19
`define SA_RAMP_PERIOD     8'h1A
`define SA_OSC_CAL         8'h1B
`define SA_BACKEND_FAULT   8'h1C
`define SA_INPUT_ROUTING   8'h20
`define SA_CH4_SOURCE      8'h21
`define SA_OUTPUT_ROUTING  8'h25
`define SA_LEFT_FILTER0    8'h29
`define SA_LEFT_FILTER1    8'h2A

// Reset values
`define RST_CLOCK_RATE      8'h6C
`define RST_FAULT_STATUS    8'h00
`define RST_SYS_CTRL_FIRST  8'hA0
`define RST_AUDIO_FORMAT    8'h05
`define RST_SYS_CTRL_SECOND 8'h40
`define RST_GENTLE_SILENCE  8'h00
`define RST_GLOBAL_GAIN     8'hFF
`define RST_CH_GAIN         8'h30
`define RST_GAIN_SETUP      8'h91
`define RST_MOD_CEILING     8'h02
`define RST_DELAY_A         8'hAC
`define RST_DELAY_B         8'h54
`define RST_SHUTDOWN_GROUP  8'h30
`define RST_RAMP_PERIOD     8'h0F
`define RST_OSC_CAL         8'h82
`define RST_BACKEND_FAULT   8'h02
`define RST_INPUT_ROUTING   32'h0001_7772
`define RST_CH4_SOURCE      32'h0000_4303
`define RST_OUTPUT_ROUTING  32'h0102_1345
`define RST_COEF_B0         32'h0080_0000

// Layout of the byte image
`define LEN_SHORT        5'h01
`define LEN_WORD         5'h04
`define LEN_FILTER       5'h14
`define IMG_BYTES        84
`define IMG_INPUT_ROUTE  7'h20
`define IMG_CH4_SOURCE   7'h24
`define IMG_OUTPUT_ROUTE 7'h28
`define IMG_FILTER0      7'h2C
`define IMG_FILTER1      7'h40
`define COEF_TOP_MASK    8'h03
`define SHUTDOWN_BIT     6
`define TRIM_START_VALUE 8'h00

// Serial control address and identity
`define BUS_ADDR_BASE    6'h1B
`define PART_ID_VALUE    8'h5A

// Timing
`define CLK_FREQ_KHZ     50000
`define TRIM_WAIT_MS     50
`define TRIM_CNT_BITS    22
`endif

/* File: core/amp_regs_pkg.sv */
package amp_regs_pkg;
   `include "amp_regs_params.svh"

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_RECV,
      PH_ACKOUT,
      PH_SEND,
      PH_ACKIN
   } bus_phase_t;

   typedef logic [`IMG_BYTES-1:0][7:0] reg_image_t;

   typedef struct packed {
      bus_phase_t                phase;
      logic [3:0]                bitCnt;
      logic [7:0]                shift;
      logic                      gotAddr;
      logic                      gotSub;
      logic                      readMode;
      logic                      acked;
      logic [7:0]                sub;
      logic [4:0]                byteCnt;
      logic                      sclPrev;
      logic                      sdaPrev;
      logic                      sdaOut;
      logic                      sdaOe;
      logic [`TRIM_CNT_BITS-1:0] trimCnt;
      logic                      trimBusy;
      logic                      shutdown;
      reg_image_t                img;
   } amp_state_t;
endpackage

/* File: verif/i2c_host_model.sv */
`timescale 1ns/100ps
module i2c_host_model (
   input  wire logic clk_sys,
   input  wire logic sdaOe,
   output logic      sclIn,
   output logic      sdaIn
);
   logic sdaRel;
   logic ackSeen;
   // Pull-up wire: released line reads high unless the device pulls it
   assign sdaIn = sdaRel & ~sdaOe;
   initial begin
      sclIn = 1'b1;
      sdaRel = 1'b1;
      ackSeen = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Four clocks per level, well over the two the device needs to see it
   task automatic bit_io(input logic b, output logic r);
      sdaRel = b;
      tick(2);
      sclIn = 1'b1;
      tick(3);
      r = sdaIn;
      tick(1);
      sclIn = 1'b0;
      tick(2);
   endtask
   task automatic start_cond();
      sdaRel = 1'b1;
      tick(2);
      sclIn = 1'b1;
      tick(4);
      sdaRel = 1'b0;
      tick(4);
      sclIn = 1'b0;
      tick(2);
   endtask
   task automatic stop_cond();
      sdaRel = 1'b0;
      tick(2);
      sclIn = 1'b1;
      tick(4);
      sdaRel = 1'b1;
      tick(4);
   endtask
   task automatic byte_io(input logic [7:0] d, input logic rel, output logic [7:0] r);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(rel, b);
      ackSeen = ~b;
   endtask
   task automatic wr_regs(input logic [6:0] dev, input logic [7:0] sub,
                          input logic [7:0] data[$], output logic ok);
      logic [7:0] junk;
      start_cond();
      byte_io({dev, 1'b0}, 1'b1, junk);
      ok = ackSeen;
      byte_io(sub, 1'b1, junk);
      foreach (data[i]) begin
         byte_io(data[i], 1'b1, junk);
         ok = ok & ackSeen;
      end
      stop_cond();
   endtask
   task automatic rd_regs(input logic [6:0] dev, input logic [7:0] sub, input int n,
                          output logic [7:0] data[$]);
      logic [7:0] b;
      data = {};
      start_cond();
      byte_io({dev, 1'b0}, 1'b1, b);
      byte_io(sub, 1'b1, b);
      start_cond();
      byte_io({dev, 1'b1}, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         byte_io(8'hFF, i == n - 1, b);
         data.push_back(b);
      end
      stop_cond();
   endtask
endmodule

/* File: verif/amp_reg_map_checker.sv */
`timescale 1ns/100ps
module amp_reg_map_checker #(
   parameter int TRIM_CYCLES = 2500000
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic shutdownActive,
   input wire logic trimBusy
);
   int busyLen;
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !trimBusy) begin
         busyLen <= 0;
      end else begin
         busyLen <= busyLen + 1;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
      else $error("data line driven high");
   AST_RESET_STATE: assert property ($past(sys_rst)
      |-> shutdownActive && !sdaOe && !trimBusy)
      else $error("outputs wrong after reset");
   AST_TRIM_BOUND: assert property (busyLen <= TRIM_CYCLES)
      else $error("trim busy too long");
   AST_TRIM_LENGTH: assert property ($fell(trimBusy) && !$past(sys_rst)
      |-> busyLen == TRIM_CYCLES)
      else $error("trim busy length wrong");
   AST_TRIM_CAUSE: assert property ($rose(trimBusy)
      |-> sdaOe || $past(sdaOe) || $past(sdaOe, 2))
      else $error("trim started outside a write");
   AST_SHUT_CAUSE: assert property ($changed(shutdownActive) && !$past(sys_rst)
      |-> sdaOe || $past(sdaOe) || $past(sdaOe, 2))
      else $error("shutdown changed outside a write");
   AST_ACK_ON_LOW: assert property ($rose(sdaOe) |-> !sclIn && !$past(sclIn))
      else $error("data line pulled while clock high");
   AST_OE_STEADY_HIGH: assert property (sclIn && $past(sclIn) && $past(sclIn, 2)
      |-> $stable(sdaOe))
      else $error("data line moved while clock high");
   cover property ($rose(trimBusy));
   cover property ($fell(shutdownActive));
   cover property ($rose(sdaOe));
endmodule

bind amp_reg_map amp_reg_map_checker #(.TRIM_CYCLES(TRIM_CYCLES)) i_amp_reg_map_checker (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .shutdownActive(shutdownActive), .trimBusy(trimBusy));

/* File: verif/tb.sv */
`timescale 1ns/100ps
`include "amp_regs_params.svh"
module tb;
   localparam int TRIM = 200;
   localparam logic [6:0] DEV = {`BUS_ADDR_BASE, 1'b1};
   logic clk_sys = 1'b0;
   logic sys_rst, sclIn, sdaIn, addrSel, sdaOut, sdaOe, shutdownActive, trimBusy, ok;
   logic [7:0] faultEvent;
   logic [7:0] q[$];
   int err_total = 0;
   int comparisons = 0;
   always #10 clk_sys = ~clk_sys;
   amp_reg_map #(.TRIM_CYCLES(TRIM)) i_amp_reg_map (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn),
      .addrSel(addrSel), .faultEvent(faultEvent), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .shutdownActive(shutdownActive), .trimBusy(trimBusy));
   i2c_host_model i_i2c_host_model (
      .clk_sys(clk_sys), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
      i_i2c_host_model.wr_regs(DEV, sub, d, ok);
      chk({31'h0, ok}, 32'h1);
   endtask
   task automatic rd_chk(input logic [7:0] sub, input int n, input logic [319:0] exp);
      logic [7:0] r[$];
      i_i2c_host_model.rd_regs(DEV, sub, n, r);
      for (int i = 0; i < n; i++) begin
         chk({24'h0, r[i]}, {24'h0, exp[8*(n-1-i) +: 8]});
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      report_and_stop();
   end
   initial begin
      sys_rst = 1'b1;
      addrSel = 1'b1;
      faultEvent = 8'h00;
      repeat (4) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      i_i2c_host_model.tick(2);
      // Whole map in bursts that stay clear of the reserved holes
      rd_chk(8'h00, 11, 320'({8'h6C, `PART_ID_VALUE, 8'h00, 8'hA0, 8'h05, 8'h40, 8'h00,
         8'hFF, 8'h30, 8'h30, 8'h30}));
      rd_chk(8'h0E, 1, 320'(8'h91));
      rd_chk(8'h10, 5, 320'({8'h02, 32'hAC54_AC54}));
      rd_chk(8'h19, 4, 320'(32'h300F_8202));
      rd_chk(8'h20, 8, 320'({32'h0001_7772, 32'h0000_4303}));
      rd_chk(8'h25, 4, 320'(32'h0102_1345));
      rd_chk(8'h29, 40, {2{32'h0080_0000, 128'h0}});
      // Foreign address must be ignored entirely
      addrSel = 1'b0;
      i_i2c_host_model.wr_regs(DEV, 8'h07, {8'h12}, ok);
      chk({31'h0, ok}, 32'h0);
      addrSel = 1'b1;
      rd_chk(8'h07, 1, 320'(8'hFF));
      wr(8'h05, {8'h00});
      chk({31'h0, shutdownActive}, 32'h0);
      wr(8'h05, {8'h40});
      chk({31'h0, shutdownActive}, 32'h1);
      wr(8'h21, {8'hDE, 8'hAD, 8'hBE, 8'hEF});
      rd_chk(8'h21, 4, 320'(32'hDEAD_BEEF));
      q = {};
      for (int i = 0; i < 20; i++) q.push_back(8'hFF);
      wr(8'h29, q);
      rd_chk(8'h29, 24, 320'({{5{32'h03FF_FFFF}}, 32'h0080_0000}));
      wr(8'h0A, {8'h55});
      wr(8'h01, {8'h11});
      rd_chk(8'h09, 2, 320'({8'h30, 8'h55}));
      rd_chk(8'h01, 1, 320'(`PART_ID_VALUE));
      faultEvent = 8'h11;
      i_i2c_host_model.tick(1);
      faultEvent = 8'h00;
      rd_chk(8'h02, 1, 320'(8'h11));
      wr(8'h02, {8'h00});
      rd_chk(8'h02, 1, 320'(8'h00));
      wr(8'h1B, {8'h00});
      chk({31'h0, trimBusy}, 32'h1);
      // Host holds off until the trim window closes
      for (int i = 0; i < TRIM + 50 && trimBusy === 1'b1; i++) i_i2c_host_model.tick(1);
      chk({31'h0, trimBusy}, 32'h0);
      rd_chk(8'h1B, 1, 320'(8'h00));
      // Reset in mid-run brings back the power-on state
      wr(8'h05, {8'h00});
      sys_rst = 1'b1;
      i_i2c_host_model.tick(4);
      sys_rst = 1'b0;
      chk({31'h0, shutdownActive}, 32'h1);
      rd_chk(8'h1B, 1, 320'(8'h82));
      report_and_stop();
   end
endmodule
